//--- common/lnf_pkg.sv
package lnf_pkg;

  // Register word offsets (byte addresses on a 32-bit Wishbone)
  localparam logic [7:0] LINK_CONTROL_REG_OFS     = 8'h00;
  localparam logic [7:0] LINK_STATUS_REG_OFS      = 8'h04;
  localparam logic [7:0] FRAME_IDENTIFIER_REG_OFS = 8'h08;
  localparam logic [7:0] FRAME_LENGTH_REG_OFS     = 8'h0c;
  localparam logic [7:0] LINK_ERROR_REG_OFS       = 8'h10;
  localparam logic [7:0] BIT_TIME_REG_OFS         = 8'h14;
  localparam logic [7:0] DATA_BUFFER_OFS          = 8'h20;

  // Control bits
  localparam int CTL_AUTOBAUD   = 0;
  localparam int CTL_ERRRST     = 2;
  localparam int CTL_INTRST     = 3;
  localparam int CTL_DATAACK    = 4;
  localparam int CTL_DIRECTION  = 5;
  localparam int CTL_ENABLE     = 6;

  // Status bits
  localparam int ST_DONE    = 0;
  localparam int ST_ERROR   = 2;
  localparam int ST_IRQ     = 3;
  localparam int ST_DATAREQ = 4;
  localparam int ST_ACTIVE  = 7;

  // Error register bits
  localparam int ERR_BIT      = 0;
  localparam int ERR_SYNC     = 1;
  localparam int ERR_TIMEOUT  = 2;
  localparam int ERR_FRAMING  = 3;

  localparam int          DATA_BYTES      = 8;
  localparam logic [15:0] BIT_TIME_RESET  = 16'h30d4; // 20 kbit/s at 250 MHz
  localparam logic [7:0]  SYNC_BYTE       = 8'h55;
  localparam int          BREAK_BITS      = 11;
  localparam int          FIFO_DEPTH      = 16;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_BREAK = 8'h02,
    ST_SYNC  = 8'h04,
    ST_PID   = 8'h08,
    ST_WAIT  = 8'h10,
    ST_RX    = 8'h20,
    ST_TX    = 8'h40,
    ST_DELIM = 8'h80
  } lnf_state_t;

  typedef struct packed {
    logic       autobaud;
    logic       enable;
    logic       direction;
  } lnf_ctrl_t;

  typedef struct packed {
    logic       bitErr;
    logic       syncErr;
    logic       timeoutErr;
    logic       framingErr;
  } lnf_err_t;

endpackage

//--- src/lnf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module lnf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wrPtr_r, rdPtr_r, wrPtr_nxt, rdPtr_nxt;
  logic [AW:0]      count_r, count_nxt;
  logic             push, pop;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    wrPtr_nxt = push ? wrPtr_r + 1'b1 : wrPtr_r;
    rdPtr_nxt = pop ? rdPtr_r + 1'b1 : rdPtr_r;
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
    if (push && !flush) begin
      mem_r[wrPtr_r] <= inData;
    end
  end
endmodule
`default_nettype wire

//--- src/lnf_slave.sv
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lnf_slave
  import lnf_pkg::*;
#(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        linRx,
  output logic             linTxOe,
  output logic             irq
);
  // Bus access
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        req, wr;
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // Pin synchroniser
  logic rxMeta_r, rxSync_r, rxPrev_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= linRx;
      rxSync_r <= rxMeta_r;
      rxPrev_r <= rxSync_r;
    end
  end

  // Registers
  lnf_ctrl_t   ctrl_r, ctrl_nxt;
  lnf_err_t    err_r, err_nxt;
  logic [5:0]  id_r, id_nxt;
  logic [3:0]  len_r, len_nxt;
  logic [15:0] bitTime_r, bitTime_nxt;
  logic        dataReq_r, dataReq_nxt, done_r, done_nxt, irq_r, irq_nxt;
  logic [7:0]  txBuf_r [DATA_BYTES];
  lnf_state_t  state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0]  bitIdx_r, bitIdx_nxt, byteIdx_r, byteIdx_nxt;
  logic [8:0]  shift_r, shift_nxt;
  logic        txOe_r, txOe_nxt, active;

  // Receive data leaves through the FIFO; software pops it from the buffer window
  logic [7:0] fifoOut;
  logic       fifoPush, fifoValid, fifoPop, fifoInReady, fifoFlush;

  lnf_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk      (clk),
    .reset    (reset),
    .flush    (fifoFlush),
    .inData   (shift_r[8:1]),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  assign active = (state_r != ST_IDLE) && (state_r != ST_WAIT);
  logic bufOk;
  assign bufOk = dataReq_r && !active;

  logic fall, halfBit, fullBit, idAck;
  assign fall    = rxPrev_r && !rxSync_r;
  assign halfBit = (cnt_r == {1'b0, bitTime_r[15:1]});
  // Counter starts at zero, so a bit lasts exactly bitTime_r cycles
  assign fullBit = (cnt_r == bitTime_r - 16'h0001);
  assign idAck   = wr && (wb_adr_i == LINK_CONTROL_REG_OFS) && wb_dat_i[CTL_DATAACK];
  assign fifoPop = req && !wb_we_i && (wb_adr_i == DATA_BUFFER_OFS) && done_r;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    err_nxt     = err_r;
    id_nxt      = id_r;
    len_nxt     = len_r;
    bitTime_nxt = bitTime_r;
    dataReq_nxt = dataReq_r;
    done_nxt    = done_r;
    irq_nxt     = irq_r;
    state_nxt   = state_r;
    cnt_nxt     = cnt_r + 16'h0001;
    bitIdx_nxt  = bitIdx_r;
    byteIdx_nxt = byteIdx_r;
    shift_nxt   = shift_r;
    txOe_nxt    = 1'b1;
    fifoPush    = 1'b0;
    fifoFlush   = 1'b0;
    // Software writes first so hardware events below win over clears
    if (wr) begin
      case (wb_adr_i)
        LINK_CONTROL_REG_OFS: begin
          ctrl_nxt.autobaud  = wb_dat_i[CTL_AUTOBAUD];
          ctrl_nxt.enable    = wb_dat_i[CTL_ENABLE];
          ctrl_nxt.direction = wb_dat_i[CTL_DIRECTION];
          if (wb_dat_i[CTL_INTRST]) begin
            irq_nxt  = 1'b0;
            done_nxt = 1'b0;
          end
          if (wb_dat_i[CTL_ERRRST]) begin
            err_nxt = '0;
          end
        end
        FRAME_LENGTH_REG_OFS: len_nxt = wb_dat_i[3:0];
        BIT_TIME_REG_OFS:     bitTime_nxt = wb_dat_i[15:0];
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r.enable && fall) begin
          state_nxt = ST_BREAK;
          cnt_nxt   = '0;
        end
      end
      ST_BREAK: begin
        if (rxSync_r) begin
          state_nxt  = (cnt_r >= 16'(BREAK_BITS - 2) * bitTime_r) ? ST_SYNC : ST_IDLE;
          bitIdx_nxt = '0;
          cnt_nxt    = '0;
        end
      end
      ST_SYNC: begin
        // Five falling edges span eight bit times
        if (fall) begin
          if (bitIdx_r == 4'h0) begin
            // Start at one so eight bit times read back exact
            cnt_nxt = 16'h0001;
          end else if (bitIdx_r == 4'h4) begin
            if (ctrl_r.autobaud) begin
              bitTime_nxt = {3'b000, cnt_r[15:3]};
            end
            state_nxt  = ST_PID;
            bitIdx_nxt = '0;
            cnt_nxt    = '0;
          end
          if (bitIdx_r != 4'h4) begin
            bitIdx_nxt = bitIdx_r + 4'h1;
          end
        end
      end
      ST_PID, ST_RX: begin
        if (bitIdx_r == 4'h0 && !fall && cnt_r > 16'h0 && state_r == ST_RX && cnt_r > 16'(12) * bitTime_r) begin
          // Response cut short by the master is a failure, not a completion
          state_nxt          = ST_IDLE;
          err_nxt.timeoutErr = 1'b1;
          irq_nxt            = 1'b1;
        end else if (bitIdx_r == 4'h0) begin
          if (fall) begin
            bitIdx_nxt = 4'h1;
            cnt_nxt    = '0;
          end
        end else if ((bitIdx_r == 4'h1 && halfBit) || (bitIdx_r != 4'h1 && fullBit)) begin
          shift_nxt  = {rxSync_r, shift_r[8:1]};
          cnt_nxt    = '0;
          bitIdx_nxt = bitIdx_r + 4'h1;
          // Start bit, eight data bits, then the stop bit at index ten
          if (bitIdx_r == 4'ha) begin
            bitIdx_nxt = '0;
            cnt_nxt    = 16'h0001;
            if (!rxSync_r) begin
              err_nxt.framingErr = 1'b1;
              irq_nxt   = 1'b1;
              state_nxt = ST_IDLE;
            end else if (state_r == ST_PID) begin
              id_nxt      = shift_r[6:1];
              dataReq_nxt = 1'b1;
              irq_nxt     = 1'b1;
              state_nxt   = ST_WAIT;
              fifoFlush   = 1'b1;
            end else begin
              fifoPush    = fifoInReady;
              byteIdx_nxt = byteIdx_r + 4'h1;
              if (byteIdx_r + 4'h1 >= len_r) begin
                state_nxt = ST_IDLE;
                done_nxt  = 1'b1;
                irq_nxt   = 1'b1;
              end
            end
          end
        end
      end
      ST_WAIT: begin
        byteIdx_nxt = '0;
        if (idAck) begin
          dataReq_nxt = 1'b0;
          bitIdx_nxt  = '0;
          cnt_nxt     = '0;
          state_nxt   = wb_dat_i[CTL_DIRECTION] ? ST_TX : ST_RX;
        end else if (fall) begin
          err_nxt.timeoutErr = 1'b1;
          irq_nxt            = 1'b1;
          dataReq_nxt        = 1'b0;
          state_nxt          = ST_IDLE;
        end
      end
      ST_TX: begin
        // Start bit, eight data bits LSB first, stop bit
        // Enable low pulls the line dominant, so it follows the bit value
        txOe_nxt = (bitIdx_r == 4'h0) ? 1'b0 :
                   (bitIdx_r == 4'h9) ? 1'b1 : txBuf_r[byteIdx_r[2:0]][3'(bitIdx_r - 4'h1)];
        if (!txOe_r && rxSync_r && halfBit) begin
          err_nxt.bitErr = 1'b1;
          irq_nxt        = 1'b1;
          state_nxt      = ST_IDLE;
          txOe_nxt       = 1'b1;
        end else if (fullBit) begin
          cnt_nxt    = '0;
          bitIdx_nxt = bitIdx_r + 4'h1;
          if (bitIdx_r == 4'h9) begin
            bitIdx_nxt  = '0;
            byteIdx_nxt = byteIdx_r + 4'h1;
            if (byteIdx_r + 4'h1 >= len_r) begin
              state_nxt = ST_IDLE;
              done_nxt  = 1'b1;
              irq_nxt   = 1'b1;
              txOe_nxt  = 1'b1;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (state_r == ST_SYNC && cnt_r == 16'hffff) begin
      err_nxt.syncErr = 1'b1;
      irq_nxt         = 1'b1;
      state_nxt       = ST_IDLE;
    end
  end

  always_comb begin
    ack_nxt   = req;
    rdata_nxt = '0;
    case (wb_adr_i)
      LINK_CONTROL_REG_OFS: rdata_nxt = {25'h0, ctrl_r.enable, ctrl_r.direction, 4'h0, ctrl_r.autobaud};
      LINK_STATUS_REG_OFS:  rdata_nxt = {24'h0, active, 2'b00, dataReq_r, irq_r, |err_r, 1'b0, done_r};
      FRAME_IDENTIFIER_REG_OFS: rdata_nxt = bufOk ? {26'h0, id_r} : '0;
      FRAME_LENGTH_REG_OFS: rdata_nxt = {28'h0, len_r};
      LINK_ERROR_REG_OFS:   rdata_nxt = {28'h0, err_r.framingErr, err_r.timeoutErr, err_r.syncErr, err_r.bitErr};
      BIT_TIME_REG_OFS:     rdata_nxt = {16'h0, bitTime_r};
      DATA_BUFFER_OFS:      rdata_nxt = {23'h0, fifoValid, fifoOut};
      default:              rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r     <= 1'b0;
      rdata_r   <= '0;
      ctrl_r    <= '0;
      err_r     <= '0;
      id_r      <= '0;
      len_r     <= '0;
      bitTime_r <= BIT_TIME_RESET;
      dataReq_r <= 1'b0;
      done_r    <= 1'b0;
      irq_r     <= 1'b0;
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      bitIdx_r  <= '0;
      byteIdx_r <= '0;
      shift_r   <= '0;
      txOe_r    <= 1'b1;
    end else begin
      ack_r     <= ack_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      err_r     <= err_nxt;
      id_r      <= id_nxt;
      len_r     <= len_nxt;
      bitTime_r <= bitTime_nxt;
      dataReq_r <= dataReq_nxt;
      done_r    <= done_nxt;
      irq_r     <= irq_nxt;
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      bitIdx_r  <= bitIdx_nxt;
      byteIdx_r <= byteIdx_nxt;
      shift_r   <= shift_nxt;
      txOe_r    <= txOe_nxt;
    end
  end

  // Transmit buffer, written only while the request is pending
  for (genvar i = 0; i < DATA_BYTES; i++) begin : g_tx
    always_ff @(posedge clk) begin
      if (reset) begin
        txBuf_r[i] <= '0;
      end else if (wr && bufOk && wb_adr_i == DATA_BUFFER_OFS + 8'(4 * i)) begin
        txBuf_r[i] <= wb_dat_i[7:0];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign linTxOe  = txOe_r;
  assign irq      = irq_r;
endmodule
`default_nettype wire

//--- verification/lnf_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lnf_slave_checker
  import lnf_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        linRx,
  input wire logic        linTxOe,
  input wire logic        irq
);
  logic       ctlWr;
  logic       rstWr;
  logic       rstPrev_r;
  logic       ackSeen_r;
  logic       rxPrev_r;
  logic [9:0] quiet_r;

  // The slave takes a write at the edge where the request meets a low ack
  assign ctlWr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0] & (wb_adr_i == LINK_CONTROL_REG_OFS);
  assign rstWr = ctlWr & wb_dat_i[CTL_INTRST];

  // Quiet time on the line bounds how late an interrupt may follow its cause
  always_ff @(posedge clk) begin
    if (reset) begin
      rstPrev_r <= 1'b0;
      ackSeen_r <= 1'b0;
      rxPrev_r  <= 1'b1;
      quiet_r   <= 10'h000;
    end else begin
      rstPrev_r <= rstWr;
      rxPrev_r  <= linRx;
      if (ctlWr & wb_dat_i[CTL_DATAACK]) begin
        ackSeen_r <= 1'b1;
      end
      quiet_r <= (linRx != rxPrev_r) ? 10'h000 : ((quiet_r == 10'h3ff) ? quiet_r : quiet_r + 10'h001);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h40 |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  idle_release_a: assert property (!ackSeen_r |-> linTxOe)
    else $error("bus driven before any acknowledge");
  irq_hold_a: assert property (irq && !rstWr && !rstPrev_r |=> irq)
    else $error("interrupt dropped without reset write");
  irq_drop_a: assert property (rstWr |-> ##[1:3] !irq)
    else $error("interrupt kept after reset write");
  irq_cause_a: assert property ($rose(irq) |-> quiet_r < 10'h190)
    else $error("interrupt without bus event");
endmodule
bind lnf_slave lnf_slave_checker chk (
  .clk(clk), .reset(reset), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .linRx(linRx), .linTxOe(linTxOe), .irq(irq)
);
`default_nettype wire

//--- verification/lnf_lin_master.sv
`timescale 1ns/1ps
`default_nettype none
module lnf_lin_master
  import lnf_pkg::*;
#(
  parameter int BITT = 20
) (
  input  wire logic clk,
  input  wire logic busLevel,
  output var logic  masterTx
);
  initial masterTx = 1'b1;

  task automatic send_bit(input logic b);
    masterTx <= b;
    repeat (BITT) @(posedge clk);
  endtask

  task automatic send_byte(input logic [7:0] d);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    send_bit(1'b1);
  endtask

  // Only the master opens a frame
  task automatic send_header(input logic [7:0] pid);
    repeat (BREAK_BITS) send_bit(1'b0);
    send_bit(1'b1);
    send_byte(SYNC_BYTE);
    send_byte(pid);
  endtask

  // Samples mid-bit; line is pulled up when nobody drives
  task automatic recv_byte(output logic [7:0] d);
    while (busLevel) @(posedge clk);
    repeat (BITT + BITT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      d[i] = busLevel;
      repeat (BITT) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb_lin_node_frame_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lin_node_frame_handshake
  import lnf_pkg::*;
;
  logic        clk    = 1'b0;
  logic        reset  = 1'b1;
  logic [7:0]  wbAdr  = 8'h00;
  logic [31:0] wbDatW = 32'h00000000;
  logic        wbWe   = 1'b0;
  logic [3:0]  wbSel  = 4'hf;
  logic        wbCyc  = 1'b0;
  logic        wbStb  = 1'b0;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic        linTxOe;
  logic        irq;
  logic        masterTx;
  wire logic   linBus;
  logic [31:0] rd;
  logic [7:0]  b0;
  logic [7:0]  b1;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cycles    = 0;

  // Open-drain line with pull-up
  assign linBus = masterTx & linTxOe;
  always #2 clk = ~clk;

  lnf_slave dut (.clk(clk), .reset(reset), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .linRx(linBus), .linTxOe(linTxOe), .irq(irq));
  lnf_lin_master #(.BITT(20)) partner (.clk(clk), .busLevel(linBus), .masterTx(masterTx));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatW <= d;
    // Look between edges so ack and data are settled, then release after the edge
    do @(negedge clk); while (wbAck !== 1'b1);
    rd = wbDatR;
    @(posedge clk);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb_cycle(a, 1'b0, 32'h00000000);
    check(what, exp, rd);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check("irq", 32'h00000001, {31'h0, irq});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd_chk(BIT_TIME_REG_OFS, {16'h0000, BIT_TIME_RESET}, "bit time");
    rd_chk(LINK_STATUS_REG_OFS, 32'h00000000, "status");
    rd_chk(FRAME_IDENTIFIER_REG_OFS, 32'h00000000, "id locked");
    rd_chk(8'h40, 32'h00000000, "unmapped");
    // Slave starts faster than the master so autobaud has work to do
    wr(BIT_TIME_REG_OFS, 32'h00000010);
    wr(LINK_CONTROL_REG_OFS, 32'h00000041);
    partner.send_header(8'h92);
    wait_irq();
    rd_chk(LINK_STATUS_REG_OFS, 32'h00000018, "status");
    rd_chk(FRAME_IDENTIFIER_REG_OFS, 32'h00000012, "id");
    rd_chk(BIT_TIME_REG_OFS, 32'h00000014, "bit time synced");
    wr(FRAME_LENGTH_REG_OFS, 32'h00000002);
    wr(LINK_CONTROL_REG_OFS, 32'h00000051);
    wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
    rd_chk(LINK_STATUS_REG_OFS, 32'h00000080, "status");
    partner.send_byte(8'ha5);
    partner.send_byte(8'h3c);
    wait_irq();
    rd_chk(LINK_STATUS_REG_OFS, 32'h00000009, "status");
    rd_chk(LINK_ERROR_REG_OFS, 32'h00000000, "error");
    rd_chk(DATA_BUFFER_OFS, 32'h000001a5, "rx0");
    rd_chk(DATA_BUFFER_OFS, 32'h0000013c, "rx1");
    // Lane zero off: the write must be ignored
    wbSel <= 4'he;
    wr(FRAME_LENGTH_REG_OFS, 32'h0000000f);
    wbSel <= 4'hf;
    rd_chk(FRAME_LENGTH_REG_OFS, 32'h00000002, "length kept");
    wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
    partner.send_header(8'h85);
    wait_irq();
    rd_chk(FRAME_IDENTIFIER_REG_OFS, 32'h00000005, "id");
    wr(FRAME_LENGTH_REG_OFS, 32'h00000002);
    wr(DATA_BUFFER_OFS, 32'h0000005a);
    wr(DATA_BUFFER_OFS + 8'h04, 32'h000000c3);
    fork
      begin
        partner.recv_byte(b0);
        partner.recv_byte(b1);
      end
      begin
        wr(LINK_CONTROL_REG_OFS, 32'h00000071);
        wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
      end
    join
    check("tx0", 32'h0000005a, {24'h0, b0});
    check("tx1", 32'h000000c3, {24'h0, b1});
    wait_irq();
    rd_chk(LINK_STATUS_REG_OFS, 32'h00000009, "status");
    wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
    // Header left unanswered, then a byte arrives
    partner.send_header(8'h92);
    wait_irq();
    wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
    rd_chk(LINK_ERROR_REG_OFS, 32'h00000000, "error");
    check("irq", 32'h00000000, {31'h0, irq});
    partner.send_byte(8'h11);
    wait_irq();
    rd_chk(LINK_ERROR_REG_OFS, 32'h00000004, "error");
    wb_cycle(LINK_STATUS_REG_OFS, 1'b0, 32'h00000000);
    check("error flag", 32'h00000001, {31'h0, rd[ST_ERROR]});
    wr(LINK_CONTROL_REG_OFS, 32'h0000004d);
    rd_chk(LINK_ERROR_REG_OFS, 32'h00000000, "error");
    final_report();
  end
endmodule
`default_nettype wire
